/* File: frt_pkg.sv */
// Shared constants and types for the free-running capture timer
package frt_pkg;

  localparam int WORD_W = 16;
  localparam int N_CAPTURE = 4;
  localparam int N_IRQ = 7;
  localparam int PRESCALE_W = 5;

  // Prescaler taps; bit k of a free divider has a period of 2^(k+1) clocks
  localparam int TAP_DIV2 = 0;
  localparam int TAP_DIV8 = 2;
  localparam int TAP_DIV32 = 4;

  localparam logic [1:0] CKS_DIV2 = 2'h0;
  localparam logic [1:0] CKS_DIV8 = 2'h1;
  localparam logic [1:0] CKS_DIV32 = 2'h2;
  localparam logic [1:0] CKS_EXT = 2'h3;

  // Register select codes on the CPU byte port
  localparam logic [2:0] SEL_COUNTER = 3'h0;
  localparam logic [2:0] SEL_CMP_A = 3'h1;
  localparam logic [2:0] SEL_CMP_B = 3'h2;
  localparam logic [2:0] SEL_CAP_A = 3'h3;

  localparam logic [15:0] COUNTER_RST = 16'h0000;
  localparam logic [15:0] COMPARE_RST = 16'hFFFF;
  localparam logic [15:0] CAPTURE_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  localparam logic [7:0] HOLD_RST = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Flag and interrupt positions, also the priority order (lowest index wins)
  localparam int IRQ_CAP_A = 0;
  localparam int IRQ_MATCH_A = 4;
  localparam int IRQ_MATCH_B = 5;
  localparam int IRQ_WRAP = 6;

  typedef enum logic [2:0] {
    ID_CAP_A = 3'b000,
    ID_CAP_B = 3'b001,
    ID_CAP_C = 3'b010,
    ID_CAP_D = 3'b011,
    ID_MATCH_A = 3'b100,
    ID_MATCH_B = 3'b101,
    ID_WRAP = 3'b110,
    ID_NONE = 3'b111
  } irq_id_t;

  typedef struct packed {
    logic [1:0] clock_select;
    logic [3:0] capture_edge_sel;
    logic [1:0] buffer_pair_en;
    logic clear_on_match_a;
    logic [1:0] match_level;
    logic [6:0] irq_enable;
  } timer_cfg_t;

  typedef struct packed {
    logic [2:0] sel;
    logic wr;
    logic rd;
    logic upper;
    logic [7:0] wdata;
  } cpu_req_t;

endpackage

/* File: frt_prescaler.sv */
// Prescaler and clock-source selection producing the counter step pulse
`timescale 1ns/1ps
`default_nettype none
module frt_prescaler
  import frt_pkg::*;
(
  input wire logic CLOCK,                // System clock
  input wire logic SYS_RST,              // Synchronous reset, high
  input wire logic [1:0] clock_select,   // Source select
  input wire logic ext_in,               // External count pin
  output logic inc_pulse                 // One-cycle step request
);

  logic [PRESCALE_W-1:0] divider;
  logic src_level;
  logic src_prev;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      divider <= '0;
    end else begin
      divider <= divider + PRESCALE_W'(1);
    end
  end

  // External pin is inverted so one falling detector serves every source
  always_comb begin
    unique case (clock_select)
      CKS_DIV2: src_level = divider[TAP_DIV2];
      CKS_DIV8: src_level = divider[TAP_DIV8];
      CKS_DIV32: src_level = divider[TAP_DIV32];
      CKS_EXT: src_level = !ext_in;
    endcase
  end

  // The previous level is of the muxed source, so a high-to-low switch counts
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_level;
    end
  end

  assign inc_pulse = src_prev && !src_level;

endmodule
`default_nettype wire

/* File: free_running_capture_timer.sv */
// 16-bit free-running counter with two compare and four capture channels
`timescale 1ns/1ps
`default_nettype none
module free_running_capture_timer
  import frt_pkg::*;
(
  input wire logic CLOCK,                 // System clock, 100 MHz
  input wire logic SYS_RST,               // Synchronous reset, high
  input wire cpu_req_t CPU,               // CPU byte access request
  output logic [7:0] CPU_RDATA,           // Read data, valid cycle after rd
  input wire timer_cfg_t CONFIG,          // Control bits
  input wire logic EXTERNAL_COUNT_IN,     // External count pin
  input wire logic [3:0] CAPTURE_IN,      // Capture pins A..D
  input wire logic [6:0] FLAG_CLEAR,      // Per-flag clear pulses
  output logic [6:0] FLAGS,               // Sticky event flags
  output logic [6:0] IRQ,                 // Interrupt request lines
  output logic IRQ_PENDING,               // Any request active
  output irq_id_t IRQ_TOP,                // Highest-priority request
  output logic [1:0] MATCH_OUT,           // Compare output pins A, B
  output logic [15:0] COUNT_VALUE         // Counter value
);

  logic [15:0] free_counter;
  logic [15:0] compare_value [2];
  logic [15:0] capture_value [N_CAPTURE];
  logic [7:0] hold_latch;
  logic [6:0] flags;
  logic [1:0] match_out;
  logic [7:0] rdata;

  logic inc_pulse;
  logic wr_lo;
  logic rd_hi;
  logic [15:0] write_word;
  logic counter_lo_write;
  logic [1:0] cmp_lo_write;
  logic [1:0] match_raw;
  logic [1:0] match;
  logic counter_clear;
  logic counter_wrap;

  logic [3:0] pin_prev;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;
  logic [3:0] edge_raw;
  logic [3:0] read_hi_cap;
  logic [3:0] cap_busy;
  logic [3:0] cap_pend;
  logic [3:0] cap_evt;
  logic [6:0] next_flags;
  logic [15:0] read_word;

  frt_prescaler u_prescaler (
    .CLOCK(CLOCK),
    .SYS_RST(SYS_RST),
    .clock_select(CONFIG.clock_select),
    .ext_in(EXTERNAL_COUNT_IN),
    .inc_pulse(inc_pulse)
  );

  // CPU access decode; every access is a one-cycle strobe, its final state
  assign wr_lo = CPU.wr && !CPU.upper;
  assign rd_hi = CPU.rd && CPU.upper;
  assign write_word = {hold_latch, CPU.wdata};
  assign counter_lo_write = wr_lo && (CPU.sel == SEL_COUNTER);
  assign cmp_lo_write[0] = wr_lo && (CPU.sel == SEL_CMP_A);
  assign cmp_lo_write[1] = wr_lo && (CPU.sel == SEL_CMP_B);

  // Match only in the state where equality is about to end with a step
  assign match_raw[0] = inc_pulse && (free_counter == compare_value[0]);
  assign match_raw[1] = inc_pulse && (free_counter == compare_value[1]);
  assign match = match_raw & ~cmp_lo_write;

  assign counter_clear = match[0] && CONFIG.clear_on_match_a;
  // A clear or a write means the step never lands, so no wrap either
  assign counter_wrap = inc_pulse && !counter_clear && !counter_lo_write
                        && (free_counter == COUNT_MAX);

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      free_counter <= COUNTER_RST;
    end else if (counter_clear) begin
      free_counter <= COUNTER_RST;
    end else if (counter_lo_write) begin
      free_counter <= write_word;
    end else if (inc_pulse) begin
      free_counter <= free_counter + COUNT_STEP;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      compare_value[0] <= COMPARE_RST;
      compare_value[1] <= COMPARE_RST;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cmp_lo_write[i]) begin
          compare_value[i] <= write_word;
        end
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      match_out <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (match[i]) begin
          match_out[i] <= CONFIG.match_level[i];
        end
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      pin_prev <= 4'h0;
    end else begin
      pin_prev <= CAPTURE_IN;
    end
  end

  assign pin_rise = CAPTURE_IN & ~pin_prev;
  assign pin_fall = ~CAPTURE_IN & pin_prev;

  // Channels C and D watch the primary pin of their pair when buffering
  for (genvar i = 0; i < N_CAPTURE; i++) begin : g_capture
    localparam int PAIR = i ^ 2;
    localparam int PRIMARY = i % 2;
    logic buffered;
    logic src_rise;
    logic src_fall;

    assign buffered = CONFIG.buffer_pair_en[PRIMARY];
    assign src_rise = (i >= 2 && buffered) ? pin_rise[PRIMARY] : pin_rise[i];
    assign src_fall = (i >= 2 && buffered) ? pin_fall[PRIMARY] : pin_fall[i];
    assign edge_raw[i] = CONFIG.capture_edge_sel[i] ? src_rise : src_fall;

    assign read_hi_cap[i] = rd_hi && (CPU.sel == SEL_CAP_A + 3'(i));
    // The pair partner's read only blocks while the pair is buffered
    assign cap_busy[i] = read_hi_cap[i] || (buffered && read_hi_cap[PAIR]);

    always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
        cap_pend[i] <= 1'b0;
      end else begin
        cap_pend[i] <= edge_raw[i] && cap_busy[i];
      end
    end

    // A held-over pulse fires regardless of a second read, so delay is one state
    assign cap_evt[i] = (edge_raw[i] && !cap_busy[i]) || cap_pend[i];
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      for (int i = 0; i < N_CAPTURE; i++) begin
        capture_value[i] <= CAPTURE_RST;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cap_evt[i]) begin
          capture_value[i] <= free_counter;
          if (CONFIG.buffer_pair_en[i]) begin
            capture_value[i + 2] <= capture_value[i];
          end
        end else if (cap_evt[i + 2] && !CONFIG.buffer_pair_en[i]) begin
          capture_value[i + 2] <= free_counter;
        end
      end
    end
  end

  // Set wins over a clear arriving in the same cycle
  always_comb begin
    next_flags = flags & ~FLAG_CLEAR;
    next_flags[IRQ_CAP_A +: N_CAPTURE] = next_flags[IRQ_CAP_A +: N_CAPTURE]
                                         | cap_evt;
    next_flags[IRQ_MATCH_A] = next_flags[IRQ_MATCH_A] | match[0];
    next_flags[IRQ_MATCH_B] = next_flags[IRQ_MATCH_B] | match[1];
    next_flags[IRQ_WRAP] = next_flags[IRQ_WRAP] | counter_wrap;
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      flags <= 7'h00;
    end else begin
      flags <= next_flags;
    end
  end

  assign IRQ = flags & CONFIG.irq_enable;
  assign IRQ_PENDING = |IRQ;

  always_comb begin
    IRQ_TOP = ID_NONE;
    for (int i = N_IRQ - 1; i >= 0; i--) begin
      if (IRQ[i]) begin
        IRQ_TOP = irq_id_t'(3'(i));
      end
    end
  end

  always_comb begin
    read_word = 16'h0000;
    if (CPU.sel == SEL_COUNTER) begin
      read_word = free_counter;
    end else if (CPU.sel == SEL_CMP_A) begin
      read_word = compare_value[0];
    end else if (CPU.sel == SEL_CMP_B) begin
      read_word = compare_value[1];
    end else begin
      for (int i = 0; i < N_CAPTURE; i++) begin
        if (CPU.sel == SEL_CAP_A + 3'(i)) begin
          read_word = capture_value[i];
        end
      end
    end
  end

  // One latch serves both directions except compare reads; interleaving other byte pairs corrupts the pair begun first
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      hold_latch <= HOLD_RST;
    end else if (CPU.wr && CPU.upper) begin
      hold_latch <= CPU.wdata;
    end else if (rd_hi && CPU.sel != SEL_CMP_A && CPU.sel != SEL_CMP_B) begin
      hold_latch <= read_word[7:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rdata <= READ_UNMAPPED;
    end else if (CPU.rd) begin
      if (CPU.sel > SEL_CAP_A + 3'(N_CAPTURE - 1)) begin
        rdata <= READ_UNMAPPED;
      end else if (CPU.upper) begin
        rdata <= read_word[15:8];
      end else if (CPU.sel == SEL_CMP_A || CPU.sel == SEL_CMP_B) begin
        rdata <= read_word[7:0];
      end else begin
        rdata <= hold_latch;
      end
    end
  end

  assign CPU_RDATA = rdata;
  assign FLAGS = flags;
  assign MATCH_OUT = match_out;
  assign COUNT_VALUE = free_counter;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  sequence s_read_blocks_a;
    edge_raw[0] && cap_busy[0];
  endsequence

  sequence s_late_capture_a;
    !cap_evt[0] ##1 cap_evt[0];
  endsequence

  a_step_advance: assert property (
    inc_pulse && !counter_clear && !counter_lo_write
    |=> free_counter == $past(free_counter) + COUNT_STEP)
    else $error("counter did not advance on step");

  a_ext_rise_step: assert property (
    CONFIG.clock_select == CKS_EXT && $stable(CONFIG.clock_select)
    && $rose(EXTERNAL_COUNT_IN) |-> inc_pulse)
    else $error("external rising edge not counted");

  // Looks back so a select change right after a step cannot fire it falsely
  a_div2_rate: assert property (
    CONFIG.clock_select == CKS_DIV2 && $past(CONFIG.clock_select) == CKS_DIV2
    && $past(CONFIG.clock_select, 2) == CKS_DIV2 && $past(inc_pulse, 2)
    |-> !$past(inc_pulse) && inc_pulse)
    else $error("divide-by-2 step spacing wrong");

  a_match_flag_set: assert property (
    match[0] |=> flags[IRQ_MATCH_A])
    else $error("match A flag not set");

  a_match_pin_level: assert property (
    match[1] |=> MATCH_OUT[1] == $past(CONFIG.match_level[1]))
    else $error("match B pin level wrong");

  a_clear_on_match: assert property (
    counter_clear |=> free_counter == COUNTER_RST)
    else $error("counter not cleared on match A");

  a_write_beats_step: assert property (
    counter_lo_write && !counter_clear && inc_pulse
    |=> free_counter == $past(write_word))
    else $error("counter write lost to step");

  a_write_hides_match: assert property (
    cmp_lo_write[0] && !flags[IRQ_MATCH_A] && !cap_evt[0]
    |=> !flags[IRQ_MATCH_A])
    else $error("match flagged during compare write");

  a_capture_delay: assert property (
    s_read_blocks_a |-> s_late_capture_a)
    else $error("capture A not delayed by one state");

  a_capture_loads: assert property (
    cap_evt[1] |=> capture_value[1] == $past(free_counter) && flags[IRQ_CAP_A + 1])
    else $error("capture B did not load counter");

  a_buffer_shift: assert property (
    cap_evt[0] && CONFIG.buffer_pair_en[0]
    |=> capture_value[2] == $past(capture_value[0]))
    else $error("buffer C did not keep old capture A");

  a_wrap_flag_set: assert property (
    counter_wrap |=> flags[IRQ_WRAP] && free_counter == COUNTER_RST)
    else $error("wrap flag not set on overflow");

endmodule
`default_nettype wire

/* File: frt_cpu_model.sv */
// CPU-side model issuing byte accesses to the timer's 16-bit registers
`timescale 1ns/1ps
`default_nettype none
module frt_cpu_model
  import frt_pkg::*;
(
  input wire logic clock,        // System clock
  input wire logic [7:0] rdata,  // Timer read data
  output var cpu_req_t req       // Byte access request
);
  initial req = '0;

  // Entered at a falling edge; the request stands for exactly one rising edge
  task automatic access(input logic [2:0] sel, input logic wr, input logic up,
                        input logic [7:0] d);
    req = '{sel: sel, wr: wr, rd: !wr, upper: up, wdata: d};
    @(negedge clock);
  endtask

  // Released lines show inverted values so a stale byte is never mistaken for a live one
  task automatic idle();
    req = '{sel: ~req.sel, wr: 1'b0, rd: 1'b0, upper: ~req.upper, wdata: ~req.wdata};
    @(negedge clock);
  endtask

  task automatic write16(input logic [2:0] sel, input logic [15:0] v);
    access(sel, 1'b1, 1'b1, v[15:8]);
    access(sel, 1'b1, 1'b0, v[7:0]);
    idle();
  endtask

  task automatic read16(input logic [2:0] sel, output logic [15:0] v);
    access(sel, 1'b0, 1'b1, 8'h00);
    v[15:8] = rdata;
    access(sel, 1'b0, 1'b0, 8'h00);
    v[7:0] = rdata;
    idle();
  endtask
endmodule
`default_nettype wire

/* File: free_running_capture_timer_test.sv */
// Self-checking bench for the free-running capture timer
`timescale 1ns/1ps
`default_nettype none
module free_running_capture_timer_test
  import frt_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  cpu_req_t cpu;
  logic [7:0] rdata;
  timer_cfg_t cfg = '0;
  logic ext = 1'b0;
  logic [3:0] cap = 4'h0;
  logic [6:0] fclr = 7'h00;
  logic [6:0] flags;
  logic [6:0] irq;
  irq_id_t top;
  logic [1:0] mout;
  logic [15:0] count;
  logic [6:0] exp_flags = 7'h00;
  logic [15:0] v;
  logic [15:0] r;
  int n;
  int n_mismatch = 0;
  int compares = 0;

  always #5 clock = ~clock;

  free_running_capture_timer i_dut (
    .CLOCK(clock), .SYS_RST(sys_rst), .CPU(cpu), .CPU_RDATA(rdata), .CONFIG(cfg),
    .EXTERNAL_COUNT_IN(ext), .CAPTURE_IN(cap), .FLAG_CLEAR(fclr), .FLAGS(flags),
    .IRQ(irq), .IRQ_PENDING(), .IRQ_TOP(top), .MATCH_OUT(mout), .COUNT_VALUE(count)
  );
  frt_cpu_model i_cpu (.clock(clock), .rdata(rdata), .req(cpu));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("Mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cycles(input int k);
    repeat (k) @(negedge clock);
  endtask

  task automatic check_flags(input string what);
    check(what, {9'h000, exp_flags}, {9'h000, flags});
  endtask

  function automatic logic [2:0] top_of(input logic [6:0] req);
    for (int i = 0; i < N_IRQ; i++) begin
      if (req[i]) return i[2:0];
    end
    return 3'h7;
  endfunction

  // Two cycles high keeps the pulse above the minimum width the pin driver owes
  task automatic ext_pulse();
    ext = 1'b1;
    cycles(2);
    ext = 1'b0;
    cycles(3);
  endtask

  task automatic clear_flags();
    fclr = 7'h7F;
    cycles(1);
    fclr = 7'h00;
    exp_flags = 7'h00;
    cycles(1);
  endtask

  task automatic check_irq();
    cfg.irq_enable = 7'($urandom());
    cycles(1);
    check("irq", {9'h000, exp_flags & cfg.irq_enable}, {9'h000, irq});
    check("irq_top", {13'h0000, top_of(exp_flags & cfg.irq_enable)}, {13'h0000, top});
  endtask

  // Counts falling edges until the counter moves; a stuck counter ends the run
  task automatic step(output int k);
    v = count;
    k = 0;
    while (count === v) begin
      cycles(1);
      k++;
      if (k > 100) begin
        $display("CHECK FAILED counter_step expected change seen %h", count);
        n_mismatch++;
        end_of_test();
      end
    end
  endtask

  initial begin
    void'($urandom(32'h1F0A));
    cycles(20);
    sys_rst = 1'b0;
    check("count_rst", COUNTER_RST, count);
    check_flags("flags_rst");
    check("top_rst", 16'h0007, {13'h0000, top});
    i_cpu.read16(SEL_CMP_A, r);
    check("cmp_a_rst", COMPARE_RST, r);
    for (int k = 0; k < 3; k++) begin
      cfg.clock_select = k[1:0];
      step(n);
      step(n);
      check("step_period", 16'(2 << (2 * k)), 16'(n));
      check("step_size", v + 16'h0001, count);
    end
    // External source with the pin idle keeps the counter still for register work
    cfg.clock_select = CKS_EXT;
    cycles(3);
    v = 16'($urandom_range(32'h7FFF));
    i_cpu.write16(SEL_COUNTER, v);
    check("count_write", v, count);
    i_cpu.read16(SEL_COUNTER, r);
    check("count_read", v, r);
    n = 1 + $urandom_range(4);
    repeat (n) ext_pulse();
    check("ext_count", v + 16'(n), count);
    // Pin rise sampled at the same edge as the counter low-byte write
    i_cpu.access(SEL_COUNTER, 1'b1, 1'b1, 8'h12);
    ext = 1'b1;
    i_cpu.access(SEL_COUNTER, 1'b1, 1'b0, 8'h34);
    i_cpu.idle();
    ext = 1'b0;
    cycles(3);
    check("write_beats_step", 16'h1234, count);
    clear_flags();
    cfg.clear_on_match_a = 1'b1;
    for (int k = 0; k < 2; k++) begin
      cfg.match_level = k[0] ? 2'h0 : 2'h3;
      v = 16'($urandom_range(32'h7FFF));
      i_cpu.write16(SEL_CMP_A, v + 16'h0002);
      i_cpu.write16(SEL_CMP_B, v + 16'h0001);
      i_cpu.read16(SEL_CMP_B, r);
      check("cmp_b_read", v + 16'h0001, r);
      i_cpu.write16(SEL_COUNTER, v);
      ext_pulse();
      ext_pulse();
      exp_flags[5] = 1'b1;
      check_flags("flags_b");
      check("pin_b", {15'h0000, ~k[0]}, {15'h0000, mout[1]});
      ext_pulse();
      exp_flags[4] = 1'b1;
      check("clear_a", 16'h0000, count);
      check_flags("flags_a");
      check("pin_a", {15'h0000, ~k[0]}, {15'h0000, mout[0]});
      check_irq();
      clear_flags();
    end
    cfg.clear_on_match_a = 1'b0;
    i_cpu.write16(SEL_COUNTER, COUNT_MAX);
    ext_pulse();
    exp_flags[6] = 1'b1;
    check("wrap_count", 16'h0000, count);
    check_flags("wrap_flag");
    check_irq();
    for (int i = 0; i < 4; i++) begin
      cfg.capture_edge_sel[i] = 1'($urandom());
      cap[i] = ~cfg.capture_edge_sel[i];
      cycles(3);
      clear_flags();
      v = 16'($urandom());
      i_cpu.write16(SEL_COUNTER, v);
      cap[i] = cfg.capture_edge_sel[i];
      cycles(3);
      exp_flags[i] = 1'b1;
      check_flags("cap_flag");
      i_cpu.read16(SEL_CAP_A + 3'(i), r);
      check("cap_value", v, r);
    end
    cfg.buffer_pair_en = 2'h1;
    cfg.capture_edge_sel[0] = 1'b1;
    cfg.capture_edge_sel[2] = 1'b0;
    cap[0] = 1'b0;
    cycles(3);
    clear_flags();
    i_cpu.write16(SEL_COUNTER, 16'h1234);
    cap[0] = 1'b1;
    cycles(3);
    cap[2] = ~cap[2];
    cycles(3);
    cap[2] = ~cap[2];
    cycles(3);
    exp_flags[0] = 1'b1;
    check_flags("buf_own_pin");
    i_cpu.write16(SEL_COUNTER, 16'h5678);
    cap[0] = 1'b0;
    cycles(3);
    exp_flags[2] = 1'b1;
    check_flags("buf_fall_flag");
    i_cpu.write16(SEL_COUNTER, 16'h9ABC);
    cap[0] = 1'b1;
    cycles(3);
    i_cpu.read16(SEL_CAP_A, r);
    check("buf_primary", 16'h9ABC, r);
    i_cpu.read16(SEL_CAP_A + 3'h2, r);
    check("buf_previous", 16'h1234, r);
    check_irq();
    end_of_test();
  end
endmodule
`default_nettype wire
